// *** rtl/mis_regs.svh ***
// register offsets, field positions and reset values of the masked status block
//
// Overview of operation
// - main masked register at 0xE258 is enable AND raw status, bit by bit.
// - main masked register is read-only; bus writes change nothing.
// - main bits 30..25: wan tx, rx, tx buf, rx buf, tx stop, rx stop.
// - main bit 24 set only while bus error response enabled and pending.
// - main bit 19 wan wake-up, bit 18 lan wake-up, enabled and pending.
// - main bits 17..12: lan tx, rx, tx buf, rx buf, tx stop, rx stop.
// - main bit 10 usb device, 9 ohci host, 8 ehci host, when enabled.
// - main bit 7 sd host, 6 security engine, 4 dram controller.
// - periph register at 0xE25C: uart4 line err 25, rx trig 24, tx empty 23.
// - periph bits 22, 21, 20: uart3 line err, rx trigger, tx empty.
// - periph bits 19, 18, 17: uart2 line err, rx trigger, tx empty.
// - periph bit 16 reports the uart modem interrupt when enabled and set.
// - periph bits 15, 14, 13: uart1 line err, rx trigger, tx empty.
// - uart line error is OR of overrun, parity, framing and break.
// - periph bit 12 management serial, bit 11 spi, when enabled and set.
// - periph bit 10 audio tx, 9 audio rx, 8 two-wire, enable AND status.
// - periph bit 7 timer one, bit 6 timer zero, when enabled and pending.
// - periph bits 5..2 report external lines 3..0 when enabled and pending.
// - periph bit 1 comm channel tx, bit 0 comm channel rx.
`ifndef MIS_REGS_SVH
`define MIS_REGS_SVH

`define MIS_OFS_MAIN        16'hE258
`define MIS_OFS_PERIPH      16'hE25C
`define MIS_RESET_VAL       32'h0000_0000
`define MIS_MAIN_VALID      32'h7F0F_F7D0
`define MIS_PERIPH_VALID    32'h03FF_FFFF

// main register fields
`define MIS_WAN_MAC_HI      30
`define MIS_WAN_MAC_LO      25
`define MIS_BUS_ERR_BIT     24
`define MIS_WAKE_HI         19
`define MIS_WAKE_LO         18
`define MIS_LAN_MAC_HI      17
`define MIS_LAN_MAC_LO      12
`define MIS_USB_HI          10
`define MIS_USB_LO          8
`define MIS_SD_BIT          7
`define MIS_SEC_BIT         6
`define MIS_DRAM_BIT        4

// periph register fields
`define MIS_UART4_HI        25
`define MIS_UART4_LO        23
`define MIS_UART3_HI        22
`define MIS_UART3_LO        20
`define MIS_UART2_HI        19
`define MIS_UART2_LO        17
`define MIS_MODEM_BIT       16
`define MIS_UART1_HI        15
`define MIS_UART1_LO        13
`define MIS_SER_HI          12
`define MIS_SER_LO          11
`define MIS_AUDIO_HI        10
`define MIS_AUDIO_LO        8
`define MIS_TIMER_HI        7
`define MIS_TIMER_LO        6
`define MIS_EXT_HI          5
`define MIS_EXT_LO          2
`define MIS_COMM_HI         1
`define MIS_COMM_LO         0

// line error bit of each uart, uart1 first
`define MIS_UART1_ERR_BIT   15
`define MIS_UART2_ERR_BIT   19
`define MIS_UART3_ERR_BIT   22
`define MIS_UART4_ERR_BIT   25
`define MIS_NUM_UARTS       4
`define MIS_LINE_CONDS      4

`endif

// *** rtl/mis_pkg.sv ***
// types shared by the masked interrupt status block
package mis_pkg;

  typedef logic [31:0] mis_word_t;

  // whole state of the top module except the two reset sync flops
  typedef struct packed {
    logic      ack;
    mis_word_t rdata;
    mis_word_t main_mask;
    mis_word_t periph_mask;
  } mis_state_t;

endpackage

// *** rtl/mis_top.sv ***
// masked interrupt status registers with an avalon-mm slave port
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`include "mis_regs.svh"

module mis_top
  import mis_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // enable and raw status from the neighbouring registers
  input  wire logic [31:0]       irq_en_main_in,
  input  wire logic [31:0]       irq_raw_main_in,
  input  wire logic [31:0]       irq_en_periph_in,
  input  wire logic [31:0]       irq_raw_periph_in,
  // per uart: {break, framing, parity, overrun}, uart1 in [3:0]
  input  wire logic [15:0]       uart_line_cond_in,
  // masked words for the priority logic
  output logic      [31:0]       masked_main_out,
  output logic      [31:0]       masked_periph_out
);

  localparam logic [ADDR_W-1:0] OFS_MAIN   = ADDR_W'(`MIS_OFS_MAIN);
  localparam logic [ADDR_W-1:0] OFS_PERIPH = ADDR_W'(`MIS_OFS_PERIPH);
  localparam int ERR_BIT [`MIS_NUM_UARTS] = '{
    `MIS_UART1_ERR_BIT, `MIS_UART2_ERR_BIT,
    `MIS_UART3_ERR_BIT, `MIS_UART4_ERR_BIT
  };

  logic [1:0]                rst_sync_r;
  logic                      rst_b;
  logic [`MIS_NUM_UARTS-1:0] line_err;
  mis_word_t                 raw_periph;
  mis_word_t                 en_m;
  mis_word_t                 en_p;
  mis_state_t                st_r;
  mis_state_t                st_nxt;
  logic                      req;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_r[1];

  // line error per uart, overriding the raw bit at its position
  genvar g;
  generate
    for (g = 0; g < `MIS_NUM_UARTS; g++) begin : g_uart
      assign line_err[g] =
        |uart_line_cond_in[g*`MIS_LINE_CONDS +: `MIS_LINE_CONDS];
    end
  endgenerate

  // raw periph word with the computed line error bits merged in
  always_comb begin
    raw_periph = irq_raw_periph_in;
    for (int i = 0; i < `MIS_NUM_UARTS; i++) begin
      raw_periph[ERR_BIT[i]] = line_err[i];
    end
  end

  // reserved positions never pass, whatever the enables hold
  assign en_m = irq_en_main_in & `MIS_MAIN_VALID;
  assign en_p = irq_en_periph_in & `MIS_PERIPH_VALID;

  assign req = avs_read_in | avs_write_in;

  // next state: masked words follow every cycle, bus answers once per request
  always_comb begin
    st_nxt = st_r;
    st_nxt.main_mask = `MIS_RESET_VAL;
    st_nxt.periph_mask = `MIS_RESET_VAL;

    // main word, field by field
    st_nxt.main_mask[`MIS_WAN_MAC_HI:`MIS_WAN_MAC_LO] =
      en_m[`MIS_WAN_MAC_HI:`MIS_WAN_MAC_LO] &
      irq_raw_main_in[`MIS_WAN_MAC_HI:`MIS_WAN_MAC_LO];
    st_nxt.main_mask[`MIS_BUS_ERR_BIT] =
      en_m[`MIS_BUS_ERR_BIT] & irq_raw_main_in[`MIS_BUS_ERR_BIT];
    st_nxt.main_mask[`MIS_WAKE_HI:`MIS_WAKE_LO] =
      en_m[`MIS_WAKE_HI:`MIS_WAKE_LO] &
      irq_raw_main_in[`MIS_WAKE_HI:`MIS_WAKE_LO];
    st_nxt.main_mask[`MIS_LAN_MAC_HI:`MIS_LAN_MAC_LO] =
      en_m[`MIS_LAN_MAC_HI:`MIS_LAN_MAC_LO] &
      irq_raw_main_in[`MIS_LAN_MAC_HI:`MIS_LAN_MAC_LO];
    st_nxt.main_mask[`MIS_USB_HI:`MIS_USB_LO] =
      en_m[`MIS_USB_HI:`MIS_USB_LO] &
      irq_raw_main_in[`MIS_USB_HI:`MIS_USB_LO];
    st_nxt.main_mask[`MIS_SD_BIT] =
      en_m[`MIS_SD_BIT] & irq_raw_main_in[`MIS_SD_BIT];
    st_nxt.main_mask[`MIS_SEC_BIT] =
      en_m[`MIS_SEC_BIT] & irq_raw_main_in[`MIS_SEC_BIT];
    st_nxt.main_mask[`MIS_DRAM_BIT] =
      en_m[`MIS_DRAM_BIT] & irq_raw_main_in[`MIS_DRAM_BIT];
    st_nxt.main_mask = st_nxt.main_mask & `MIS_MAIN_VALID;

    // periph word, field by field
    st_nxt.periph_mask[`MIS_UART4_HI:`MIS_UART4_LO] =
      en_p[`MIS_UART4_HI:`MIS_UART4_LO] &
      raw_periph[`MIS_UART4_HI:`MIS_UART4_LO];
    st_nxt.periph_mask[`MIS_UART3_HI:`MIS_UART3_LO] =
      en_p[`MIS_UART3_HI:`MIS_UART3_LO] &
      raw_periph[`MIS_UART3_HI:`MIS_UART3_LO];
    st_nxt.periph_mask[`MIS_UART2_HI:`MIS_UART2_LO] =
      en_p[`MIS_UART2_HI:`MIS_UART2_LO] &
      raw_periph[`MIS_UART2_HI:`MIS_UART2_LO];
    st_nxt.periph_mask[`MIS_MODEM_BIT] =
      en_p[`MIS_MODEM_BIT] & raw_periph[`MIS_MODEM_BIT];
    st_nxt.periph_mask[`MIS_UART1_HI:`MIS_UART1_LO] =
      en_p[`MIS_UART1_HI:`MIS_UART1_LO] &
      raw_periph[`MIS_UART1_HI:`MIS_UART1_LO];
    st_nxt.periph_mask[`MIS_SER_HI:`MIS_SER_LO] =
      en_p[`MIS_SER_HI:`MIS_SER_LO] &
      raw_periph[`MIS_SER_HI:`MIS_SER_LO];
    st_nxt.periph_mask[`MIS_AUDIO_HI:`MIS_AUDIO_LO] =
      en_p[`MIS_AUDIO_HI:`MIS_AUDIO_LO] &
      raw_periph[`MIS_AUDIO_HI:`MIS_AUDIO_LO];
    st_nxt.periph_mask[`MIS_TIMER_HI:`MIS_TIMER_LO] =
      en_p[`MIS_TIMER_HI:`MIS_TIMER_LO] &
      raw_periph[`MIS_TIMER_HI:`MIS_TIMER_LO];
    st_nxt.periph_mask[`MIS_EXT_HI:`MIS_EXT_LO] =
      en_p[`MIS_EXT_HI:`MIS_EXT_LO] &
      raw_periph[`MIS_EXT_HI:`MIS_EXT_LO];
    st_nxt.periph_mask[`MIS_COMM_HI:`MIS_COMM_LO] =
      en_p[`MIS_COMM_HI:`MIS_COMM_LO] &
      raw_periph[`MIS_COMM_HI:`MIS_COMM_LO];

    // bus: one wait cycle, then a one-cycle acknowledge.
    // read data comes from the registered words, so a read sees the
    // value as of the edge that opened the answer, not a later one.
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack) begin
      if (avs_read_in && avs_address_in == OFS_MAIN) begin
        st_nxt.rdata = st_r.main_mask;
      end else if (avs_read_in && avs_address_in == OFS_PERIPH) begin
        st_nxt.rdata = st_r.periph_mask;
      end else begin
        // unmapped reads and writes give zero
        st_nxt.rdata = `MIS_RESET_VAL;
      end
    end
    // writes are acknowledged and dropped: nothing here is writable
  end

  // single state register
  always_ff @(posedge mclk_in or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_waitrequest_out = req & ~st_r.ack;
  assign avs_readdata_out    = st_r.rdata;
  assign masked_main_out     = st_r.main_mask;
  assign masked_periph_out   = st_r.periph_mask;

endmodule

// *** verification/mis_checker_asserts.sv ***
// concurrent checks on the ports of the masked status block
`timescale 1ns/1ps
`include "mis_regs.svh"

module mis_checker
  import mis_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic              mclk_in,
  input wire logic              rst_b_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic              avs_read_in,
  input wire logic              avs_write_in,
  input wire logic [31:0]       avs_readdata_out,
  input wire logic              avs_waitrequest_out,
  input wire logic [31:0]       irq_en_main_in,
  input wire logic [31:0]       irq_raw_main_in,
  input wire logic [31:0]       irq_en_periph_in,
  input wire logic [31:0]       irq_raw_periph_in,
  input wire logic [15:0]       uart_line_cond_in,
  input wire logic [31:0]       masked_main_out,
  input wire logic [31:0]       masked_periph_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // counts edges after release, since the design sees reset two flops late
  logic [1:0] up_r;
  logic       ack;
  logic [3:0] err_en;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      up_r <= 2'h0;
    else if (up_r != 2'h3)
      up_r <= up_r + 2'h1;
  end
  // line error per uart, gated by its enable, uart4 first
  assign err_en = {irq_en_periph_in[25], irq_en_periph_in[22],
                   irq_en_periph_in[19], irq_en_periph_in[15]} &
                  {|uart_line_cond_in[15:12], |uart_line_cond_in[11:8],
                   |uart_line_cond_in[7:4], |uart_line_cond_in[3:0]};
  assign ack = avs_read_in && !avs_waitrequest_out;

  chk_main_and: assert property (up_r == 2'h3 |-> masked_main_out ==
    ($past(irq_en_main_in) & $past(irq_raw_main_in) & `MIS_MAIN_VALID))
    else $error("main masked word wrong");
  chk_periph_and: assert property (up_r == 2'h3 |->
    ((masked_periph_out ^ $past(irq_en_periph_in) & $past(irq_raw_periph_in))
     & `MIS_PERIPH_VALID & ~32'h0248_8000) == 32'h0000_0000)
    else $error("periph masked word wrong");
  chk_uart_err: assert property (up_r == 2'h3 |-> $past(err_en) ==
    {masked_periph_out[25], masked_periph_out[22],
     masked_periph_out[19], masked_periph_out[15]})
    else $error("uart line error bit wrong");
  chk_rsvd_zero: assert property ((masked_main_out & ~`MIS_MAIN_VALID) ==
    0 && (masked_periph_out & ~`MIS_PERIPH_VALID) == 0)
    else $error("reserved bit set");
  chk_reset_zero: assert property (up_r != 2'h3 |->
    masked_main_out == 0 && masked_periph_out == 0)
    else $error("masked word not clear after reset");
  chk_one_wait: assert property ($rose(avs_read_in || avs_write_in) |->
    avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("wait cycle count wrong");
  chk_read_main: assert property (ack && up_r == 2'h3 &&
    avs_address_in == `MIS_OFS_MAIN |-> avs_readdata_out ==
    $past(masked_main_out)) else $error("main read data wrong");
  chk_read_periph: assert property (ack && up_r == 2'h3 &&
    avs_address_in == `MIS_OFS_PERIPH |-> avs_readdata_out ==
    $past(masked_periph_out)) else $error("periph read data wrong");
  chk_unmapped_zero: assert property (ack && avs_address_in !=
    `MIS_OFS_MAIN && avs_address_in != `MIS_OFS_PERIPH |->
    avs_readdata_out == 0) else $error("unmapped read not zero");
endmodule

bind mis_top mis_checker #(.ADDR_W(ADDR_W)) mis_checker_inst (.mclk_in,
  .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .irq_en_main_in,
  .irq_raw_main_in, .irq_en_periph_in, .irq_raw_periph_in,
  .uart_line_cond_in, .masked_main_out, .masked_periph_out);

// *** verification/tb.sv ***
// self-checking bench for the masked status block
`timescale 1ns/1ps
`include "mis_regs.svh"

module tb;
  import mis_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        rd_r = 1'b0;
  logic        wr_r = 1'b0;
  logic [15:0] addr_r = 16'h0000;
  logic [15:0] cond_r = 16'h0000;
  mis_word_t   wdata_r = '0, en_m = '0, raw_m = '0, en_p = '0, raw_p = '0;
  logic [31:0] rdata, mm, mp;
  logic        wq;
  mis_word_t   exp_q[$];
  mis_word_t   exp_w;
  int          n_mismatch = 0, comparisons = 0, cyc = 0, i;
  int          seed = 32'hbc1fe472;

  mis_top mis_top_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .avs_address_in(addr_r), .avs_read_in(rd_r), .avs_write_in(wr_r),
    .avs_writedata_in(wdata_r), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wq),
    .irq_en_main_in(en_m), .irq_raw_main_in(raw_m),
    .irq_en_periph_in(en_p), .irq_raw_periph_in(raw_p),
    .uart_line_cond_in(cond_r), .masked_main_out(mm),
    .masked_periph_out(mp));

  always #2 mclk_in = ~mclk_in;

  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // a hang in the bus handshake ends the run here
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict;
    end
  end

  // expected word worked out from the inputs as the bench drives them
  function automatic mis_word_t exp_word(input logic [15:0] a);
    mis_word_t e;
    e = raw_p;
    e[15] = |cond_r[3:0];
    e[19] = |cond_r[7:4];
    e[22] = |cond_r[11:8];
    e[25] = |cond_r[15:12];
    if (a == `MIS_OFS_MAIN)
      return en_m & raw_m & `MIS_MAIN_VALID;
    if (a == `MIS_OFS_PERIPH)
      return e & en_p & `MIS_PERIPH_VALID;
    return 32'h0000_0000;
  endfunction

  task cmp_word(input logic [31:0] got, input mis_word_t exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t readdata %h expected %h", $time, got, exp);
    end
  endtask

  task cmp_mask(input logic [31:0] got, input mis_word_t exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t masked output %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; the first edge lets earlier input changes settle.
  // the request stands until waitrequest is seen low at a rising edge;
  // only the bench timeout ends a wait that never ends
  task bus(input logic wr, input logic [15:0] a, input mis_word_t d);
    @(posedge mclk_in);
    if (!wr)
      exp_q.push_back(exp_word(a));
    addr_r <= a;
    wdata_r <= d;
    rd_r <= !wr;
    wr_r <= wr;
    do begin
      @(posedge mclk_in);
    end while (wq !== 1'b0);
    rd_r <= 1'b0;
    wr_r <= 1'b0;
  endtask

  // watcher: every acknowledged read retires the oldest note; the masked
  // output of the register read must agree with that note at that edge
  always @(posedge mclk_in) begin
    if (rd_r && wq === 1'b0) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[ERR] %0t read answered with no note", $time);
      end else begin
        exp_w = exp_q.pop_front();
        cmp_word(rdata, exp_w);
        if (addr_r == `MIS_OFS_MAIN)
          cmp_mask(mm, exp_w);
        if (addr_r == `MIS_OFS_PERIPH)
          cmp_mask(mp, exp_w);
      end
    end
  end

  initial begin
    repeat (10) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    bus(1'b0, `MIS_OFS_MAIN, '0);
    bus(1'b0, `MIS_OFS_PERIPH, '0);
    $display("test reset values done");
    // random sources, reads one idle cycle apart including an unmapped place
    for (i = 0; i < 40; i++) begin
      en_m <= 32'($random(seed));
      raw_m <= 32'($random(seed));
      en_p <= 32'($random(seed));
      raw_p <= 32'($random(seed));
      cond_r <= 16'($random(seed));
      bus(1'b0, `MIS_OFS_MAIN, '0);
      bus(1'b0, `MIS_OFS_PERIPH, '0);
      bus(1'b0, 16'hE260, '0);
    end
    $display("test random masking done");
    bus(1'b1, `MIS_OFS_MAIN, 32'hFFFF_FFFF);
    bus(1'b1, `MIS_OFS_PERIPH, 32'($random(seed)));
    bus(1'b0, `MIS_OFS_MAIN, '0);
    bus(1'b0, `MIS_OFS_PERIPH, '0);
    $display("test writes ignored done");
    // each line condition alone must raise its uart error bit
    en_p <= 32'hFFFF_FFFF;
    raw_p <= 32'h0000_0000;
    for (i = 0; i < 16; i++) begin
      cond_r <= 16'h0001 << i;
      bus(1'b0, `MIS_OFS_PERIPH, '0);
    end
    $display("test line conditions done");
    // reset in mid-run with every source but the uart line conditions live: words clear, then track
    en_m <= 32'hFFFF_FFFF;
    raw_m <= 32'hFFFF_FFFF;
    raw_p <= 32'hFFFF_FFFF;
    cond_r <= 16'h0000;
    rst_b_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    bus(1'b0, `MIS_OFS_MAIN, '0);
    bus(1'b0, `MIS_OFS_PERIPH, '0);
    $display("test mid-run reset done");
    repeat (2) @(posedge mclk_in);
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("[ERR] %0t reads left unanswered", $time);
    end
    give_verdict;
  end
endmodule
